// >>> rtl/lbu_pkg.sv
package lbu_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // instruction encoding
    localparam logic [7:0] PREFIX_BYTE = 8'h18;
    localparam logic [7:0] OP_ALWAYS   = 8'h20;
    localparam logic [7:0] OP_NEVER    = 8'h21;
    localparam logic [7:0] OP_HI       = 8'h22;
    localparam logic [7:0] OP_LS       = 8'h23;
    localparam logic [7:0] OP_CC       = 8'h24;
    localparam logic [7:0] OP_CS       = 8'h25;
    localparam logic [7:0] OP_NE       = 8'h26;
    localparam logic [7:0] OP_EQ       = 8'h27;
    localparam logic [7:0] OP_VC       = 8'h28;
    localparam logic [7:0] OP_VS       = 8'h29;
    localparam logic [7:0] OP_PL       = 8'h2A;
    localparam logic [7:0] OP_MI       = 8'h2B;
    localparam logic [7:0] OP_GE       = 8'h2C;
    localparam logic [7:0] OP_LT       = 8'h2D;
    localparam logic [7:0] OP_GT       = 8'h2E;
    localparam logic [7:0] OP_LE       = 8'h2F;
    localparam logic [3:0] OP_FAMILY   = 4'h2;

    ////////////////////////////////////////////////////////////////////////////////
    // flag positions in the 4-bit N Z V C input
    localparam int FLAG_N = 3;
    localparam int FLAG_Z = 2;
    localparam int FLAG_V = 1;
    localparam int FLAG_C = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // address arithmetic and timing
    localparam logic [15:0] PC_STEP       = 16'h0004;
    localparam logic [15:0] PC_RESET      = 16'h0000;
    localparam int          CYCLES_TAKEN  = 4;
    localparam int          CYCLES_SKIP   = 3;

    ////////////////////////////////////////////////////////////////////////////////
    // sequencer states
    typedef enum logic [5:0] {
        ST_IDLE   = 6'b000001,
        ST_OPCODE = 6'b000010,
        ST_OFS_HI = 6'b000100,
        ST_OFS_LO = 6'b001000,
        ST_REFILL = 6'b010000,
        ST_DONE   = 6'b100000
    } lbu_state_t;

endpackage : lbu_pkg

// >>> rtl/lbu_cond_eval.sv
`timescale 1ns/10ps
module lbu_cond_eval (
    // opcode and flags
    input  wire logic [7:0] i_opcode,
    input  wire logic [3:0] i_flags,
    // result
    output logic            o_valid,
    output logic            o_taken
);
    logic n;
    logic z;
    logic v;
    logic c;

    assign n = i_flags[lbu_pkg::FLAG_N];
    assign z = i_flags[lbu_pkg::FLAG_Z];
    assign v = i_flags[lbu_pkg::FLAG_V];
    assign c = i_flags[lbu_pkg::FLAG_C];
    assign o_valid = (i_opcode[7:4] == lbu_pkg::OP_FAMILY);

    // pairs differ only in bit 0, so each pair shares one test
    always_comb begin
        case (i_opcode)
            lbu_pkg::OP_LE:     o_taken = z | (n ^ v);
            lbu_pkg::OP_GT:     o_taken = ~(z | (n ^ v));
            lbu_pkg::OP_GE:     o_taken = ~(n ^ v);
            lbu_pkg::OP_LT:     o_taken = n ^ v;
            lbu_pkg::OP_HI:     o_taken = ~(c | z);
            lbu_pkg::OP_LS:     o_taken = c | z;
            lbu_pkg::OP_CC:     o_taken = ~c;
            lbu_pkg::OP_CS:     o_taken = c;
            lbu_pkg::OP_EQ:     o_taken = z;
            lbu_pkg::OP_NE:     o_taken = ~z;
            lbu_pkg::OP_MI:     o_taken = n;
            lbu_pkg::OP_PL:     o_taken = ~n;
            lbu_pkg::OP_VS:     o_taken = v;
            lbu_pkg::OP_VC:     o_taken = ~v;
            lbu_pkg::OP_ALWAYS: o_taken = 1'b1;
            lbu_pkg::OP_NEVER:  o_taken = 1'b0;
            default:            o_taken = 1'b0;
        endcase
    end
endmodule : lbu_cond_eval

// >>> rtl/lbu_long_branch.sv
`timescale 1ns/10ps
module lbu_long_branch (
    // clock and reset
    input  wire logic        I_CLK,
    input  wire logic        I_RST,
    // instruction byte stream
    input  wire logic        I_BYTE_VALID,
    input  wire logic [7:0]  I_BYTE,
    input  wire logic [15:0] I_INSTR_PC,
    // condition flags N Z V C
    input  wire logic [3:0]  I_FLAGS,
    // byte stream accepted
    output logic             O_BYTE_READY,
    // result
    output logic             O_DONE,
    output logic             O_TAKEN,
    output logic             O_ILLEGAL,
    output logic [15:0]      O_NEXT_PC,
    output logic [3:0]       O_FLAGS,
    output logic             O_REFILL_BUSY,
    output logic [2:0]       O_REFILL_CYCLES
);
    ////////////////////////////////////////////////////////////////////////////////
    // state
    lbu_pkg::lbu_state_t state_q;
    logic [7:0]  opcode_q;
    logic [7:0]  ofs_hi_q;
    logic [15:0] base_pc_q;
    logic [15:0] target_q;
    logic        taken_q;
    logic [3:0]  flags_q;
    logic [2:0]  refill_left_q;
    logic [2:0]  refill_total_q;
    logic        cond_valid;
    logic        cond_taken;
    logic        take_byte;

    function automatic logic [15:0] rel_target(input logic [15:0] pc, input logic [15:0] rel);
        rel_target = pc + lbu_pkg::PC_STEP + rel;
    endfunction : rel_target

    lbu_cond_eval u_cond (
        .i_opcode (opcode_q),
        .i_flags  (flags_q),
        .o_valid  (cond_valid),
        .o_taken  (cond_taken)
    );

    assign O_BYTE_READY = (state_q == lbu_pkg::ST_IDLE) || (state_q == lbu_pkg::ST_OPCODE)
                       || (state_q == lbu_pkg::ST_OFS_HI) || (state_q == lbu_pkg::ST_OFS_LO);
    assign take_byte    = I_BYTE_VALID && O_BYTE_READY;
    assign O_REFILL_BUSY = (state_q == lbu_pkg::ST_REFILL);

    ////////////////////////////////////////////////////////////////////////////////
    // decode sequencer
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            state_q <= lbu_pkg::ST_IDLE;
        end else begin
            case (state_q)
                lbu_pkg::ST_IDLE: begin
                    if (take_byte && I_BYTE == lbu_pkg::PREFIX_BYTE) begin
                        state_q <= lbu_pkg::ST_OPCODE;
                    end
                end
                lbu_pkg::ST_OPCODE: begin
                    if (take_byte) begin
                        state_q <= (I_BYTE[7:4] == lbu_pkg::OP_FAMILY) ? lbu_pkg::ST_OFS_HI
                                                                     : lbu_pkg::ST_DONE;
                    end
                end
                lbu_pkg::ST_OFS_HI: begin
                    if (take_byte) begin
                        state_q <= lbu_pkg::ST_OFS_LO;
                    end
                end
                lbu_pkg::ST_OFS_LO: begin
                    if (take_byte) begin
                        state_q <= lbu_pkg::ST_REFILL;
                    end
                end
                lbu_pkg::ST_REFILL: begin
                    if (refill_left_q == 3'h1) begin
                        state_q <= lbu_pkg::ST_DONE;
                    end
                end
                lbu_pkg::ST_DONE: state_q <= lbu_pkg::ST_IDLE;
                default:          state_q <= lbu_pkg::ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // operand capture; flags sampled once at the opcode so a late change cannot split a test
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            opcode_q  <= 8'h00;
            ofs_hi_q  <= 8'h00;
            base_pc_q <= lbu_pkg::PC_RESET;
            flags_q   <= 4'h0;
        end else if (take_byte) begin
            if (state_q == lbu_pkg::ST_IDLE) begin
                base_pc_q <= I_INSTR_PC;
            end
            if (state_q == lbu_pkg::ST_OPCODE) begin
                opcode_q <= I_BYTE;
                flags_q  <= I_FLAGS;
            end
            if (state_q == lbu_pkg::ST_OFS_HI) begin
                ofs_hi_q <= I_BYTE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // target and refill count, settled when the low offset byte arrives
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            target_q       <= lbu_pkg::PC_RESET;
            taken_q        <= 1'b0;
            refill_left_q  <= 3'h0;
            refill_total_q <= 3'h0;
        end else if (take_byte && state_q == lbu_pkg::ST_OFS_LO) begin
            taken_q <= cond_taken;
            if (cond_taken) begin
                target_q       <= rel_target(base_pc_q, {ofs_hi_q, I_BYTE});
                refill_left_q  <= 3'(lbu_pkg::CYCLES_TAKEN);
                refill_total_q <= 3'(lbu_pkg::CYCLES_TAKEN);
            end else begin
                target_q       <= base_pc_q + lbu_pkg::PC_STEP;
                refill_left_q  <= 3'(lbu_pkg::CYCLES_SKIP);
                refill_total_q <= 3'(lbu_pkg::CYCLES_SKIP);
            end
        end else if (state_q == lbu_pkg::ST_REFILL) begin
            refill_left_q <= refill_left_q - 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // result outputs
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_DONE          <= 1'b0;
            O_TAKEN         <= 1'b0;
            O_ILLEGAL       <= 1'b0;
            O_NEXT_PC       <= lbu_pkg::PC_RESET;
            O_FLAGS         <= 4'h0;
            O_REFILL_CYCLES <= 3'h0;
        end else begin
            O_DONE <= 1'b0;
            if (state_q == lbu_pkg::ST_REFILL && refill_left_q == 3'h1) begin
                O_DONE          <= 1'b1;
                O_TAKEN         <= taken_q;
                O_ILLEGAL       <= 1'b0;
                O_NEXT_PC       <= target_q;
                O_FLAGS         <= flags_q;
                O_REFILL_CYCLES <= refill_total_q;
            end else if (take_byte && state_q == lbu_pkg::ST_OPCODE
                         && I_BYTE[7:4] != lbu_pkg::OP_FAMILY) begin
                // not a long branch: hand back untouched, caller decodes elsewhere
                O_DONE    <= 1'b1;
                O_TAKEN   <= 1'b0;
                O_ILLEGAL <= 1'b1;
                O_NEXT_PC <= base_pc_q;
                O_FLAGS   <= I_FLAGS;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    a_pc_target: assert property (@(posedge I_CLK) disable iff (I_RST)
        (take_byte && state_q == lbu_pkg::ST_OFS_LO && cond_taken)
        |=> (target_q == base_pc_q + 16'h0004 + {ofs_hi_q, $past(I_BYTE)}))
        else $error("taken target wrong");
    a_refill_taken: assert property (@(posedge I_CLK) disable iff (I_RST)
        (take_byte && state_q == lbu_pkg::ST_OFS_LO && cond_taken)
        |=> O_REFILL_BUSY [*4] ##1 (O_DONE && O_TAKEN))
        else $error("taken refill not four cycles");
    a_refill_skip: assert property (@(posedge I_CLK) disable iff (I_RST)
        (take_byte && state_q == lbu_pkg::ST_OFS_LO && !cond_taken)
        |=> O_REFILL_BUSY [*3] ##1 (O_DONE && !O_TAKEN))
        else $error("skip refill not three cycles");
    a_skip_next_pc: assert property (@(posedge I_CLK) disable iff (I_RST)
        (O_DONE && !O_TAKEN && !O_ILLEGAL) |-> (O_NEXT_PC == $past(base_pc_q) + 16'h0004))
        else $error("fall-through pc wrong");
    a_flags_kept: assert property (@(posedge I_CLK) disable iff (I_RST)
        (O_DONE && !O_ILLEGAL) |-> (O_FLAGS == $past(flags_q)))
        else $error("flags altered");
    a_prefix_decode: assert property (@(posedge I_CLK) disable iff (I_RST)
        (state_q == lbu_pkg::ST_IDLE && take_byte && I_BYTE != 8'h18)
        |=> (state_q == lbu_pkg::ST_IDLE))
        else $error("non-prefix started decode");
    a_family_valid: assert property (@(posedge I_CLK) disable iff (I_RST)
        (state_q == lbu_pkg::ST_OFS_HI) |-> cond_valid)
        else $error("offset fetch for a non-branch opcode");
    a_le_formula: assert property (@(posedge I_CLK) disable iff (I_RST)
        (opcode_q == 8'h2F) |-> (cond_taken == (flags_q[2] | (flags_q[3] ^ flags_q[1]))))
        else $error("signed le test wrong");
    a_gt_complement: assert property (@(posedge I_CLK) disable iff (I_RST)
        (opcode_q == 8'h2E) |-> (cond_taken == !(flags_q[2] | (flags_q[3] ^ flags_q[1]))))
        else $error("gt not complement of le");
    a_le_signed: assert property (@(posedge I_CLK) disable iff (I_RST)
        (opcode_q == 8'h2F && flags_q == 4'h8) |-> cond_taken)
        else $error("signed negative result not le");
    a_pair_le: assert property (@(posedge I_CLK) disable iff (I_RST)
        (opcode_q == 8'h2F && flags_q == 4'h0) |-> !cond_taken)
        else $error("positive nonzero difference taken");
    c_taken: cover property (@(posedge I_CLK) O_DONE && O_TAKEN);
    c_skip: cover property (@(posedge I_CLK) O_DONE && !O_TAKEN && !O_ILLEGAL);
    c_illegal: cover property (@(posedge I_CLK) O_DONE && O_ILLEGAL);
endmodule : lbu_long_branch

// >>> testbench/lbu_long_branch_bench.sv
`timescale 1ns/10ps
module lbu_long_branch_bench;

    logic        clk;
    logic        rst;
    logic        byte_valid;
    logic [7:0]  bus_byte;
    logic [15:0] instr_pc;
    logic [3:0]  flags;
    logic        byte_ready;
    logic        done;
    logic        taken;
    logic        illegal;
    logic [15:0] next_pc;
    logic [3:0]  flags_out;
    logic        refill_busy;
    logic [2:0]  refill_cycles;
    int          failures;
    int          tests_run;

    lbu_long_branch dut (
        .I_CLK           (clk),
        .I_RST           (rst),
        .I_BYTE_VALID    (byte_valid),
        .I_BYTE          (bus_byte),
        .I_INSTR_PC      (instr_pc),
        .I_FLAGS         (flags),
        .O_BYTE_READY    (byte_ready),
        .O_DONE          (done),
        .O_TAKEN         (taken),
        .O_ILLEGAL       (illegal),
        .O_NEXT_PC       (next_pc),
        .O_FLAGS         (flags_out),
        .O_REFILL_BUSY   (refill_busy),
        .O_REFILL_CYCLES (refill_cycles)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic end_of_test;
        $display("tests_run %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test

    // reference condition, written apart from the design on purpose
    function automatic logic want(input logic [7:0] op, input logic [3:0] f);
        case (op[3:0])
            4'h0: want = 1'b1;
            4'h1: want = 1'b0;
            4'h2: want = ~(f[0] | f[2]);
            4'h3: want = f[0] | f[2];
            4'h4: want = ~f[0];
            4'h5: want = f[0];
            4'h6: want = ~f[2];
            4'h7: want = f[2];
            4'h8: want = ~f[1];
            4'h9: want = f[1];
            4'hA: want = ~f[3];
            4'hB: want = f[3];
            4'hC: want = ~(f[3] ^ f[1]);
            4'hD: want = f[3] ^ f[1];
            4'hE: want = ~(f[2] | (f[3] ^ f[1]));
            default: want = f[2] | (f[3] ^ f[1]);
        endcase
    endfunction : want

    function automatic logic [3:0] sub_flags(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] d;
        d = {1'b0, a} - {1'b0, b};
        sub_flags = {d[15], d[15:0] == 16'h0000, (a[15] ^ b[15]) & (d[15] ^ a[15]), d[16]};
    endfunction : sub_flags

    task automatic put(input logic [7:0] b);
        byte_valid <= 1'b1;
        bus_byte   <= b;
        @(posedge clk);
    endtask : put

    // called at the edge that takes the last byte; returns 1 ns after done rises
    task automatic wait_done(output int n, output int busy);
        n = 0;
        busy = 0;
        #1;
        while (done !== 1'b1 && n < 20) begin
            if (refill_busy === 1'b1)
                busy++;
            @(posedge clk);
            #1;
            n++;
        end
    endtask : wait_done

    ////////////////////////////////////////////////////////////////////////////////
    task automatic run_branch(input logic [7:0] op, input logic [3:0] f,
                              input logic [15:0] pc, input logic [15:0] ofs);
        logic tk;
        int   n;
        int   busy;
        int   want_n;
        tk = want(op, f);
        want_n = tk ? lbu_pkg::CYCLES_TAKEN : lbu_pkg::CYCLES_SKIP;
        instr_pc <= pc;
        put(lbu_pkg::PREFIX_BYTE);
        // later changes on pc and flags must not leak into the result
        instr_pc <= ~pc;
        flags    <= f;
        put(op);
        flags <= ~f;
        put(ofs[15:8]);
        put(ofs[7:0]);
        byte_valid <= 1'b0;
        wait_done(n, busy);
        check(16'(n), 16'(want_n), "done latency");
        check(16'(busy), 16'(want_n), "refill busy");
        check({13'h0000, refill_cycles}, 16'(want_n), "refill count");
        check({15'h0000, byte_ready}, 16'h0000, "ready while done");
        check({15'h0000, taken}, {15'h0000, tk}, "taken");
        check(next_pc, pc + lbu_pkg::PC_STEP + (tk ? ofs : 16'h0000), "next pc");
        check({12'h000, flags_out}, {12'h000, f}, "flags");
        check({15'h0000, illegal}, 16'h0000, "illegal");
        @(posedge clk);
    endtask : run_branch

    task automatic t_all_ops;
        logic [15:0] i;
        for (int k = 0; k < 256; k++) begin
            i = 16'(k);
            run_branch({4'h2, i[7:4]}, i[3:0], i * 16'h0F13, i * 16'h9E37);
        end
    endtask : t_all_ops

    task automatic t_signed_compare;
        logic [15:0] r [8] = '{16'hFFFF, 16'h0005, 16'h7FFF, 16'h8000, 16'h1234,
                               16'hFF80, 16'h007F, 16'h0000};
        logic [15:0] m [8] = '{16'h0001, 16'hFFFD, 16'h8000, 16'h7FFF, 16'h1234,
                               16'h007F, 16'hFF80, 16'hFFFF};
        for (int k = 0; k < 8; k++) begin
            // the last three rows stand for a sign-extended accumulator pair
            run_branch(lbu_pkg::OP_LE, sub_flags(r[k], m[k]), 16'h4000, 16'hFFF0);
            check({15'h0000, taken}, {15'h0000, $signed(r[k]) <= $signed(m[k])}, "signed le");
        end
    endtask : t_signed_compare

    task automatic t_illegal;
        int n;
        int busy;
        instr_pc <= 16'hA5C3;
        put(8'h55);
        put(lbu_pkg::PREFIX_BYTE);
        put(8'h30);
        byte_valid <= 1'b0;
        wait_done(n, busy);
        check(16'(n), 16'h0000, "illegal latency");
        check({15'h0000, illegal}, 16'h0001, "illegal flag");
        check({15'h0000, taken}, 16'h0000, "illegal taken");
        check(next_pc, 16'hA5C3, "illegal pc");
        @(posedge clk);
    endtask : t_illegal

    // reset in mid refill must drop the refill and clear the result
    task automatic t_mid_reset;
        instr_pc <= 16'h1000;
        put(lbu_pkg::PREFIX_BYTE);
        put(lbu_pkg::OP_ALWAYS);
        put(8'h00);
        put(8'h10);
        byte_valid <= 1'b0;
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        check({15'h0000, refill_busy}, 16'h0000, "busy after reset");
        check({15'h0000, byte_ready}, 16'h0001, "ready after reset");
        check({15'h0000, done}, 16'h0000, "done after reset");
        check(next_pc, lbu_pkg::PC_RESET, "pc after reset");
        @(posedge clk);
        run_branch(lbu_pkg::OP_LE, 4'h4, 16'h2000, 16'h0100);
    endtask : t_mid_reset

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst        = 1'b1;
        byte_valid = 1'b0;
        bus_byte   = 8'h00;
        instr_pc   = 16'h0000;
        flags      = 4'h0;
        failures   = 0;
        tests_run  = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        check({15'h0000, done}, 16'h0000, "reset done");
        check({15'h0000, byte_ready}, 16'h0001, "reset ready");
        @(posedge clk);
        t_all_ops;
        t_illegal;
        t_signed_compare;
        t_mid_reset;
        end_of_test;
    end

    // about 2300 cycles are expected; the limit leaves ample margin
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        $display("[FAIL] %0t watchdog expired", $time);
        end_of_test;
    end

endmodule : lbu_long_branch_bench
